// ---- wake_irq_params.svh ----
// constants for the wake input and interrupt pulse logic
// assumes a 250 MHz core clock; included by the package and the module
`ifndef WAKE_IRQ_PARAMS_SVH
`define WAKE_IRQ_PARAMS_SVH

`define CLK_PERIOD_NS        4
`define WAKE_FILTER_TIME_NS  16000
`define IRQ_PULSE_TIME_NS    100000
`define IRQ_GAP_TIME_NS      100000
// least times round up to whole cycles
`define NS_TO_CYCLES_UP(t)   (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define FILT_CNT_W           12
`define IRQ_CNT_W            17
`define STAT_W               8

// register byte offsets
`define ADR_HARDWARE_CONTROL_REG          8'h00
`define ADR_WAKE_CTRL        8'h04
`define ADR_BIAS_CTRL        8'h08
`define ADR_STAT_FIRST       8'h0c
`define ADR_STAT_SECOND      8'h10
`define ADR_LEVEL_STAT       8'h14

// field positions
`define BIT_MOD_BY_PIN       0
`define BIT_WAKE_EN          0
`define BIT_CYCLIC           1
`define BIT_PIN_WAKE         0
`define BIT_LEVEL            0

// bias select codes
`define BIAS_NONE            2'h0
`define BIAS_PULL_DOWN       2'h1
`define BIAS_PULL_UP         2'h2
`define BIAS_AUTO            2'h3

`endif

// ---- wake_irq_pkg.sv ----
// types shared by the wake input and interrupt pulse logic
// the constants live in wake_irq_params.svh
`include "wake_irq_params.svh"

package wake_irq_pkg;

  // device operating mode as driven by the mode controller
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'h0,
    MODE_STOP     = 2'h1,
    MODE_SLEEP    = 2'h3,
    MODE_FAILSAFE = 2'h2
  } dev_mode_t;

  // gray along idle -> pulse -> gap; gap -> idle flips both bits
  typedef enum logic [1:0] {
    IRQ_IDLE  = 2'h0,
    IRQ_PULSE = 2'h1,
    IRQ_GAP   = 2'h3
  } irq_state_t;

  typedef struct packed {
    logic [2:0]             sync;
    logic                   filt_level;
    logic [`FILT_CNT_W-1:0] filt_cnt;
    logic                   mod_by_pin;
    logic                   wake_en;
    logic                   cyclic;
    logic [1:0]             bias;
    logic [`STAT_W-1:0]     shadow_first;
    logic [`STAT_W-1:0]     shadow_second;
    logic [`STAT_W-1:0]     stat_first;
    logic [`STAT_W-1:0]     stat_second;
    logic                   irq_pend;
    irq_state_t             irq_st;
    logic [`IRQ_CNT_W-1:0]  irq_cnt;
    dev_mode_t              mode_prev;
    logic                   ack;
    logic [31:0]            dat;
    logic                   irq_n;
    logic                   wake_req;
    logic                   restart_req;
    logic                   pwm_sel;
    logic                   pull_up;
    logic                   pull_down;
  } wake_state_t;

endpackage : wake_irq_pkg

// ---- wake_input_interrupt_logic.sv ----
// wake pin edge detection, mode dependent wake or interrupt, bias select,
// pin driven buck modulation select and the active-low interrupt pulse.
// assumes: mode comes from the mode controller on core_clk; ext_* events
// are single-cycle pulses already gated by their own wake enables.
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "wake_irq_params.svh"

module wake_input_interrupt_logic
  import wake_irq_pkg::*;
#(
  parameter int unsigned IRQ_PULSE_CYCLES =
    `NS_TO_CYCLES_UP(`IRQ_PULSE_TIME_NS),
  parameter int unsigned IRQ_GAP_CYCLES   =
    `NS_TO_CYCLES_UP(`IRQ_GAP_TIME_NS)
)(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [7:0]        wb_adr,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [31:0]       wb_dat_wr,
  output logic      [31:0]       wb_dat_rd,
  output logic                   wb_ack,
  input  wire logic              wake_pin,
  input  wire dev_mode_t         mode,
  input  wire logic              cyclic_window,
  input  wire logic [`STAT_W-1:1] ext_wake_first,
  input  wire logic [`STAT_W-1:0] ext_wake_second,
  input  wire logic              buck_auto_pwm,
  output logic                   irq_line_n,
  output logic                   wake_request,
  output logic                   restart_request,
  output logic                   pwm_select,
  output logic                   pull_up_en,
  output logic                   pull_down_en
);

  localparam int unsigned FILT_CYCLES =
    `NS_TO_CYCLES_UP(`WAKE_FILTER_TIME_NS);

  function automatic logic cnt_done(input logic [`IRQ_CNT_W-1:0] c,
                                    input int unsigned n);
    cnt_done = (c == `IRQ_CNT_W'(n - 1));
  endfunction : cnt_done

  wake_state_t state_reg;
  wake_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // combinational next state

  logic                   agree;
  logic                   sense_on;
  logic                   pin_event;
  logic                   run_mode;
  logic                   sleep_wake;
  logic                   fs_restart;
  logic                   irq_cause;
  logic                   copy_stat;
  logic                   bus_req;
  logic                   wr_lo;
  logic [`STAT_W-1:0]     clr_first;
  logic [`STAT_W-1:0]     clr_second;
  logic [`STAT_W-1:0]     new_first;
  logic [`STAT_W-1:0]     new_second;

  always_comb
  begin
    state_next = state_reg;
    state_next.sync = {state_reg.sync[1:0], wake_pin};

    // synced level counts only once second and third flops agree
    agree = (state_reg.sync[1] == state_reg.sync[2]);
    // cyclic sense looks at the pin only inside its window
    sense_on = !state_reg.cyclic || cyclic_window;
    pin_event = 1'b0;
    if (agree && sense_on && state_reg.sync[2] != state_reg.filt_level)
    begin
      if (state_reg.filt_cnt == `FILT_CNT_W'(FILT_CYCLES - 1))
      begin
        state_next.filt_level = state_reg.sync[2];
        state_next.filt_cnt   = '0;
        pin_event             = 1'b1;
      end
      else
      begin
        state_next.filt_cnt = state_reg.filt_cnt + `FILT_CNT_W'(1);
      end
    end
    else
    begin
      state_next.filt_cnt = '0;
    end

    run_mode   = (mode == MODE_NORMAL) || (mode == MODE_STOP);
    sleep_wake = pin_event && state_reg.wake_en
                 && mode == MODE_SLEEP;
    fs_restart = pin_event && mode == MODE_FAILSAFE;
    state_next.wake_req    = sleep_wake;
    state_next.restart_req = fs_restart;

    // in Normal/Stop events latch into a shadow first; the visible copy follows at pulse start
    new_first  = {ext_wake_first, 1'b0};
    new_second = ext_wake_second;
    if ((pin_event && state_reg.wake_en) || fs_restart)
      new_first[`BIT_PIN_WAKE] = 1'b1;

    // level status is deliberately absent from every cause below
    irq_cause = run_mode && (
                  (pin_event && state_reg.wake_en)
                  || (|ext_wake_first) || (|ext_wake_second)
                  || (mode == MODE_STOP && state_reg.mode_prev != MODE_STOP
                      && (|{state_reg.stat_first, state_reg.stat_second,
                            state_reg.shadow_first,
                            state_reg.shadow_second}))
                  || (mode == MODE_STOP && buck_auto_pwm));
    state_next.mode_prev = mode;

    // pulse generator; it drives no mode change
    copy_stat = 1'b0;
    case (state_reg.irq_st)
      IRQ_IDLE:
      begin
        if (state_reg.irq_pend && run_mode)
        begin
          state_next.irq_st = IRQ_PULSE;
          state_next.irq_n  = 1'b0;
          state_next.irq_cnt = '0;
          copy_stat         = 1'b1;
        end
      end
      IRQ_PULSE:
      begin
        if (cnt_done(state_reg.irq_cnt, IRQ_PULSE_CYCLES))
        begin
          state_next.irq_st  = IRQ_GAP;
          state_next.irq_n   = 1'b1;
          state_next.irq_cnt = '0;
        end
        else
        begin
          state_next.irq_cnt = state_reg.irq_cnt + `IRQ_CNT_W'(1);
        end
      end
      IRQ_GAP:
      begin
        if (cnt_done(state_reg.irq_cnt, IRQ_GAP_CYCLES))
          state_next.irq_st = IRQ_IDLE;
        else
          state_next.irq_cnt = state_reg.irq_cnt + `IRQ_CNT_W'(1);
      end
      default:
      begin
        state_next.irq_st = IRQ_IDLE;
        state_next.irq_n  = 1'b1;
      end
    endcase

    // a new cause in the start cycle stays pending for the next pulse
    if (!run_mode)
      state_next.irq_pend = 1'b0;
    else
      state_next.irq_pend = (state_reg.irq_pend && !copy_stat)
                            || irq_cause;

    // outside Normal/Stop no pulse starts, status follows at once
    if (!run_mode)
      copy_stat = 1'b1;

    // bus slave: answer one cycle after the request, drop ack after
    bus_req = wb_cyc && wb_stb && !state_reg.ack;
    wr_lo   = bus_req && wb_we && wb_sel[0];
    state_next.ack = bus_req;
    clr_first  = '0;
    clr_second = '0;
    if (wr_lo)
    begin
      case (wb_adr)
        `ADR_HARDWARE_CONTROL_REG:
          state_next.mod_by_pin = wb_dat_wr[`BIT_MOD_BY_PIN];
        `ADR_WAKE_CTRL:
        begin
          state_next.wake_en = wb_dat_wr[`BIT_WAKE_EN];
          state_next.cyclic  = wb_dat_wr[`BIT_CYCLIC];
        end
        `ADR_BIAS_CTRL:
          state_next.bias = wb_dat_wr[1:0];
        `ADR_STAT_FIRST:
          clr_first = wb_dat_wr[`STAT_W-1:0];
        `ADR_STAT_SECOND:
          clr_second = wb_dat_wr[`STAT_W-1:0];
        default:
          state_next.mod_by_pin = state_reg.mod_by_pin;
      endcase
    end

    // write-one-to-clear; a set in the same cycle wins
    if (copy_stat)
    begin
      state_next.stat_first  = (state_reg.stat_first & ~clr_first)
                               | state_reg.shadow_first | new_first;
      state_next.stat_second = (state_reg.stat_second & ~clr_second)
                               | state_reg.shadow_second | new_second;
      state_next.shadow_first  = '0;
      state_next.shadow_second = '0;
    end
    else
    begin
      state_next.stat_first  = state_reg.stat_first & ~clr_first;
      state_next.stat_second = state_reg.stat_second & ~clr_second;
      state_next.shadow_first  = state_reg.shadow_first | new_first;
      state_next.shadow_second = state_reg.shadow_second | new_second;
    end

    state_next.dat = '0;
    if (bus_req && !wb_we)
    begin
      case (wb_adr)
        `ADR_HARDWARE_CONTROL_REG:
          state_next.dat[`BIT_MOD_BY_PIN] = state_reg.mod_by_pin;
        `ADR_WAKE_CTRL:
        begin
          state_next.dat[`BIT_WAKE_EN] = state_reg.wake_en;
          state_next.dat[`BIT_CYCLIC]  = state_reg.cyclic;
        end
        `ADR_BIAS_CTRL:
          state_next.dat[1:0] = state_reg.bias;
        `ADR_STAT_FIRST:
          state_next.dat[`STAT_W-1:0] = state_reg.stat_first;
        `ADR_STAT_SECOND:
          state_next.dat[`STAT_W-1:0] = state_reg.stat_second;
        `ADR_LEVEL_STAT:
          state_next.dat[`BIT_LEVEL] = run_mode
                                       && state_reg.filt_level;
        default:
          state_next.dat = '0;
      endcase
    end

    // modulation select follows the synced pin with no filter
    if (state_reg.mod_by_pin && mode == MODE_STOP)
      state_next.pwm_sel = state_reg.sync[2];
    else
      state_next.pwm_sel = 1'b0;

    case (state_reg.bias)
      `BIAS_PULL_DOWN:
      begin
        state_next.pull_up   = 1'b0;
        state_next.pull_down = 1'b1;
      end
      `BIAS_PULL_UP:
      begin
        state_next.pull_up   = 1'b1;
        state_next.pull_down = 1'b0;
      end
      `BIAS_AUTO:
      begin
        state_next.pull_up   = state_reg.filt_level;
        state_next.pull_down = !state_reg.filt_level;
      end
      default:
      begin
        state_next.pull_up   = 1'b0;
        state_next.pull_down = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg           <= '0;
      state_reg.irq_st    <= IRQ_IDLE;
      state_reg.mode_prev <= MODE_NORMAL;
      state_reg.irq_n     <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_rd       = state_reg.dat;
  assign wb_ack          = state_reg.ack;
  assign irq_line_n      = state_reg.irq_n;
  assign wake_request    = state_reg.wake_req;
  assign restart_request = state_reg.restart_req;
  assign pwm_select      = state_reg.pwm_sel;
  assign pull_up_en      = state_reg.pull_up;
  assign pull_down_en    = state_reg.pull_down;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // cycles spent low and high, helper for the pulse checks
  logic [`IRQ_CNT_W-1:0] low_cnt;
  logic [`IRQ_CNT_W-1:0] high_cnt;
  logic                  seen_pulse;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      low_cnt    <= '0;
      high_cnt   <= '0;
      seen_pulse <= 1'b0;
    end
    else
    begin
      low_cnt  <= irq_line_n ? '0 : low_cnt + `IRQ_CNT_W'(1);
      high_cnt <= irq_line_n ? high_cnt + `IRQ_CNT_W'(1) : '0;
      if (!irq_line_n)
        seen_pulse <= 1'b1;
    end
  end

  a_pulse_width: assert property (
    $rose(irq_line_n) |-> $past(low_cnt) == `IRQ_CNT_W'(IRQ_PULSE_CYCLES - 1))
    else $error("interrupt pulse width wrong");
  a_gap_min: assert property (
    $fell(irq_line_n) && seen_pulse |->
      $past(high_cnt) >= `IRQ_CNT_W'(IRQ_GAP_CYCLES))
    else $error("interrupt gap too short");
  a_filter_stable: assert property (
    $changed(state_reg.filt_level) |->
      $past(state_reg.filt_cnt) == `FILT_CNT_W'(FILT_CYCLES - 1))
    else $error("pin level accepted before filter time");
  a_run_edge_irq: assert property (
    pin_event && state_reg.wake_en && mode == MODE_NORMAL |=>
      state_reg.irq_pend ##[1:3] !irq_line_n || state_reg.irq_st != IRQ_IDLE)
    else $error("pin edge in normal mode gave no interrupt");
  a_sleep_wake: assert property (
    pin_event && state_reg.wake_en && mode == MODE_SLEEP |=>
      wake_request && state_reg.stat_first[`BIT_PIN_WAKE])
    else $error("pin edge did not wake from sleep");
  a_failsafe_restart: assert property (
    pin_event && mode == MODE_FAILSAFE |=> restart_request ##1 !restart_request)
    else $error("pin edge in fail-safe gave no restart request");
  a_pwm_follow: assert property (
    state_reg.mod_by_pin && mode == MODE_STOP |=>
      pwm_select == $past(state_reg.sync[2]))
    else $error("modulation select does not follow pin");
  a_auto_bias: assert property (
    state_reg.bias == `BIAS_AUTO |=>
      pull_up_en == $past(state_reg.filt_level) && pull_up_en != pull_down_en)
    else $error("automatic bias wrong");
  a_status_on_fall: assert property (
    $fell(irq_line_n) |->
      (state_reg.stat_first & $past(state_reg.shadow_first))
        == $past(state_reg.shadow_first))
    else $error("status not updated at pulse start");
  a_no_irq_sleep: assert property (
    mode == MODE_SLEEP && state_reg.irq_st == IRQ_IDLE |=> irq_line_n)
    else $error("interrupt started in sleep");

  c_two_pulses: cover property ($fell(irq_line_n) && seen_pulse);
  c_sleep_wake: cover property (wake_request);
  c_fs_restart: cover property (restart_request);
  c_pend_in_gap: cover property (
    state_reg.irq_st == IRQ_GAP && irq_cause);

endmodule : wake_input_interrupt_logic

// ---- mcu_irq_model.sv ----
// microcontroller side of the interrupt line: counts and times pulses
// assumes irq_line_n is synchronous to core_clk
`timescale 1ns/1ns

module mcu_irq_model (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic irq_line_n,
  output int        pulse_count,
  output int        width_last,
  output int        gap_min
);
  logic prev_reg;
  int   run_reg;

  // a receiver only measures; widths are in whole core_clk cycles
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_reg    <= 1'b1;
      run_reg     <= 0;
      pulse_count <= 0;
      width_last  <= 0;
      gap_min     <= 1000000;
    end
    else
    begin
      prev_reg <= irq_line_n;
      run_reg  <= (prev_reg !== irq_line_n) ? 1 : run_reg + 1;
      if (prev_reg === 1'b1 && irq_line_n === 1'b0)
      begin
        pulse_count <= pulse_count + 1;
        // gap only counts between two pulses, not from reset
        if (pulse_count > 0 && run_reg < gap_min)
          gap_min <= run_reg;
      end
      if (prev_reg === 1'b0 && irq_line_n === 1'b1)
        width_last <= run_reg;
    end
  end
endmodule : mcu_irq_model

// ---- tb.sv ----
// self-checking bench for the wake input and interrupt pulse logic
// assumes short pulse and gap parameters; filter stays at 4000 cycles
`timescale 1ns/1ns

module tb
  import wake_irq_pkg::*;
;
  localparam int P = 20;
  localparam int G = 20;
  localparam int FILT_WAIT = 4200;

  typedef struct {
    dev_mode_t m;
    logic en, pin, irq, wk, rs, flag;
  } row_t;

  logic core_clk, rstn, wb_cyc, wb_stb, wb_we, wake_pin, cyclic_window;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_wr, wb_dat_rd, q;
  logic        wb_ack, buck_auto_pwm, irq_line_n, wake_request;
  logic        restart_request, pwm_select, pull_up_en, pull_down_en;
  logic [7:0]  ext_wake_second;
  logic [6:0]  ext_wake_first;
  logic        lvl;
  dev_mode_t   mode;
  int          failures, total_checks, wk_seen, rs_seen, base;
  int          pulse_count, width_last, gap_min;
  row_t        rows [0:5] = '{
    '{MODE_NORMAL,   1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1},
    '{MODE_STOP,     1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
    '{MODE_SLEEP,    1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1},
    '{MODE_FAILSAFE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
    '{MODE_NORMAL,   1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
    '{MODE_SLEEP,    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}};

  wake_input_interrupt_logic #(
    .IRQ_PULSE_CYCLES (P),
    .IRQ_GAP_CYCLES   (G)
  ) u_dut (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .wb_cyc          (wb_cyc),
    .wb_stb          (wb_stb),
    .wb_we           (wb_we),
    .wb_adr          (wb_adr),
    .wb_sel          (wb_sel),
    .wb_dat_wr       (wb_dat_wr),
    .wb_dat_rd       (wb_dat_rd),
    .wb_ack          (wb_ack),
    .wake_pin        (wake_pin),
    .mode            (mode),
    .cyclic_window   (cyclic_window),
    .ext_wake_first  (ext_wake_first),
    .ext_wake_second (ext_wake_second),
    .buck_auto_pwm   (buck_auto_pwm),
    .irq_line_n      (irq_line_n),
    .wake_request    (wake_request),
    .restart_request (restart_request),
    .pwm_select      (pwm_select),
    .pull_up_en      (pull_up_en),
    .pull_down_en    (pull_down_en)
  );

  mcu_irq_model u_mcu (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .irq_line_n  (irq_line_n),
    .pulse_count (pulse_count),
    .width_last  (width_last),
    .gap_min     (gap_min)
  );

  ////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string what);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // classic single cycle; request held until ack is sampled high
  task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc    <= 1'b1;
    wb_stb    <= 1'b1;
    wb_we     <= we;
    wb_adr    <= a;
    wb_dat_wr <= d;
    wb_sel    <= 4'hf;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_dat_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20)
    begin
      check(1'b0, 1'b1, "bus ack timeout");
      print_verdict();
    end
  endtask : wb_xfer

  task watch(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      if (wake_request === 1'b1) wk_seen++;
      if (restart_request === 1'b1) rs_seen++;
    end
  endtask : watch

  task set_mode(input dev_mode_t m);
    @(posedge core_clk);
    mode <= m;
  endtask : set_mode

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial
  begin
    {failures, total_checks} = 0;
    {rstn, wb_cyc, wb_stb, wb_we, wake_pin, cyclic_window} = '0;
    {wb_adr, wb_sel, wb_dat_wr, ext_wake_second, buck_auto_pwm} = '0;
    ext_wake_first = '0;
    mode = MODE_NORMAL;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    check(irq_line_n, 1'b1, "irq idle after reset");
    check({pull_up_en, pull_down_en}, 2'h0, "bias after reset");
    for (int a = 0; a <= 8'h18; a += 4)
    begin
      wb_xfer(1'b0, a[7:0], 32'h0);
      check(q, 32'h0, "reset value");
    end
    wb_xfer(1'b1, 8'h18, 32'hff);
    wb_xfer(1'b0, 8'h18, 32'h0);
    check(q, 32'h0, "unmapped read");

    // edge in each mode; Normal and Sleep with and without wake enable, Stop with it, fail-safe without
    foreach (rows[i])
    begin
      set_mode(rows[i].m);
      wb_xfer(1'b1, 8'h04, {31'h0, rows[i].en});
      base = pulse_count;
      {wk_seen, rs_seen} = 0;
      wake_pin <= rows[i].pin;
      watch(FILT_WAIT);
      check(pulse_count - base, rows[i].irq, "irq pulses");
      check(wk_seen, rows[i].wk, "wake requests");
      check(rs_seen, rows[i].rs, "restart requests");
      wb_xfer(1'b0, 8'h0c, 32'h0);
      check(q[0], rows[i].flag, "pin wake flag");
      wb_xfer(1'b0, 8'h14, 32'h0);
      lvl = rows[i].m == MODE_NORMAL || rows[i].m == MODE_STOP;
      check(q[0], lvl && rows[i].pin, "level status");
      wb_xfer(1'b1, 8'h0c, 32'h1);
    end

    // bias codes with the filtered level high
    wake_pin <= 1'b1;
    watch(FILT_WAIT);
    for (int c = 0; c < 4; c++)
    begin
      wb_xfer(1'b1, 8'h08, c);
      watch(4);
      q = (c == 3) ? 2'h2 : c[1:0];
      check({pull_up_en, pull_down_en}, q, "bias enables");
    end

    // pin as modulation select follows the raw level, well inside filter
    wb_xfer(1'b1, 8'h00, 32'h1);
    set_mode(MODE_STOP);
    watch(8);
    check(pwm_select, 1'b1, "pwm by pin high");
    wake_pin <= 1'b0;
    watch(8);
    check(pwm_select, 1'b0, "pfm by pin low");
    wake_pin <= 1'b1;
    watch(8);
    set_mode(MODE_NORMAL);
    watch(8);
    check(pwm_select, 1'b0, "no pin select outside stop");
    wb_xfer(1'b1, 8'h00, 32'h0);

    // two causes back to back: second waits out pulse and gap
    set_mode(MODE_STOP);
    base = pulse_count;
    @(posedge core_clk);
    buck_auto_pwm <= 1'b1;
    @(posedge core_clk);
    buck_auto_pwm <= 1'b0;
    watch(10);
    buck_auto_pwm <= 1'b1;
    @(posedge core_clk);
    buck_auto_pwm <= 1'b0;
    watch(4 * (P + G));
    check(pulse_count - base, 2, "held cause pulses");
    check(width_last, P, "pulse width");
    check(gap_min >= G, 1'b1, "gap between pulses");

    // latched event held until cleared; entering stop re-signals it
    set_mode(MODE_NORMAL);
    base = pulse_count;
    @(posedge core_clk);
    {ext_wake_first, ext_wake_second} <= {7'h02, 8'h08};
    @(posedge core_clk);
    {ext_wake_first, ext_wake_second} <= '0;
    watch(2 * (P + G));
    check(pulse_count - base, 1, "latched event irq");
    wb_xfer(1'b0, 8'h10, 32'h0);
    wb_xfer(1'b0, 8'h10, 32'h0);
    check(q, 32'h08, "status held");
    wb_xfer(1'b0, 8'h0c, 32'h0);
    check(q, 32'h04, "first status held");
    set_mode(MODE_STOP);
    watch(2 * (P + G));
    check(pulse_count - base, 2, "stop with status set");
    wb_xfer(1'b1, 8'h10, 32'h08);
    wb_xfer(1'b0, 8'h10, 32'h0);
    check(q, 32'h0, "status cleared");
    wb_xfer(1'b1, 8'h0c, 32'h04);
    wb_xfer(1'b0, 8'h0c, 32'h0);
    check(q, 32'h0, "first status cleared");

    // cyclic sense ignores the pin while the window is shut
    set_mode(MODE_NORMAL);
    wb_xfer(1'b1, 8'h04, 32'h3);
    base = pulse_count;
    wake_pin <= 1'b0;
    watch(FILT_WAIT);
    check(pulse_count - base, 0, "cyclic window shut");
    cyclic_window <= 1'b1;
    watch(FILT_WAIT);
    check(pulse_count - base, 1, "cyclic window open");
    print_verdict();
  end
endmodule : tb
